// *** smb_client.sv ***
// Client end: two-wire register port with pointer, time-out and alert answer
// Behaviour
// - Address byte: seven bits then direction
// - Strap code picks client address
// - Bytes are eight bits, MSB first
// - Client acks own address, ARA with unmasked alert, and every written byte
// - Host nacks last read byte
// - Stop resets client state machine
// - Enabled 30ms inactivity resets interface
// - Enabled 150us idle resets protocol
// - Host clock at least 10kHz
// - Write Byte stores data at pointer
// - Read Byte: pointer, restart, one byte
// - Send Byte loads pointer only
// - Receive Byte rereads pointed register
// - Block Write fills contiguous registers
// - Block Read returns contiguous registers
// - ARA read returns own address
// - Mask alert after clean address send
// - Client never stretches clock
// - Start is data falling, clock high
`timescale 1ns/10ps
module smb_client #(
	parameter int unsigned TIMEOUT_CYCLES = smb_pkg::TIMEOUT_CYC,
	parameter int unsigned IDLE_CYCLES = smb_pkg::IDLE_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	smb_if.client bus,
	input wire logic [3:0] addr_strap,
	input wire logic timeout_en,
	input wire logic idle_en,
	input wire logic alert_req,
	input wire logic alert_mask_clr,
	output logic alert_mask,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata,
	output logic [6:0] own_addr
);
	import smb_pkg::*;
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic scl_q_r;
	logic sda_q_r;
	logic strap_done_r;
	cl_state_t st_r;
	logic [2:0] bit_r;
	byte_t sh_r;
	logic rw_r;
	logic ara_r;
	logic first_r;
	logic adv_r;
	logic [3:0] strap_m_r;
	logic [3:0] strap_s_r;
	logic [1:0] strap_vld_r;
	logic lost_r;
	logic oe_r;
	logic [31:0] to_cnt_r;
	logic [31:0] idle_cnt_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], bus.scl};
			sda_s_r <= {sda_s_r[0], bus.sda};
			scl_q_r <= scl_s_r[1];
			sda_q_r <= sda_s_r[1];
		end
	end
	wire scl = scl_s_r[1];
	wire sda = sda_s_r[1];
	wire scl_rise = scl & ~scl_q_r;
	wire scl_fall = ~scl & scl_q_r;
	wire start_det = scl & scl_q_r & sda_q_r & ~sda;
	wire stop_det = scl & scl_q_r & ~sda_q_r & sda;
	wire to_hit = timeout_en && (to_cnt_r >= TIMEOUT_CYCLES);
	wire idle_hit = idle_en && (idle_cnt_r >= IDLE_CYCLES) && st_r != CL_IDLE;
	wire bus_rst = stop_det | to_hit | idle_hit;
	wire [7:0] sh_in = {sh_r[6:0], sda};
	wire addr_match = sh_in[7:1] == own_addr;
	wire ara_match = sh_in[7:1] == ARA_ADDR && sh_in[0] && alert_req && !alert_mask;
	wire [7:0] tx_byte = ara_r ? {own_addr, 1'b1} : reg_rdata;
	// Strap pin crosses two stages, then is latched once after reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_m_r <= STRAP_OPEN;
			strap_s_r <= STRAP_OPEN;
			strap_vld_r <= 2'h0;
			strap_done_r <= 1'b0;
			own_addr <= OPEN_ADDR;
		end else begin
			strap_m_r <= addr_strap;
			strap_s_r <= strap_m_r;
			strap_vld_r <= {strap_vld_r[0], 1'b1};
			if (strap_vld_r[1] && !strap_done_r) begin
				strap_done_r <= 1'b1;
				own_addr <= strap_addr(strap_s_r);
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			to_cnt_r <= '0;
			idle_cnt_r <= '0;
		end else begin
			to_cnt_r <= (scl && st_r == CL_IDLE) || to_hit || scl_rise ? '0 : to_cnt_r + 32'h1;
			idle_cnt_r <= (scl && sda) && !idle_hit ? idle_cnt_r + 32'h1 : '0;
		end
	end
	// Data is driven only on falling clock: the client never holds the clock
	assign bus.dat_dev_oe = oe_r;
	assign bus.alert_n = ~(alert_req & ~alert_mask);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= CL_IDLE;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			ara_r <= 1'b0;
			first_r <= 1'b0;
			adv_r <= 1'b0;
			lost_r <= 1'b0;
			oe_r <= 1'b0;
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			alert_mask <= 1'b0;
		end else begin
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			if (alert_mask_clr) begin
				alert_mask <= 1'b0;
			end
			if (bus_rst) begin
				st_r <= CL_IDLE;
				oe_r <= 1'b0;
			end else if (start_det) begin
				st_r <= CL_ADDR;
				bit_r <= 3'h0;
				oe_r <= 1'b0;
				adv_r <= 1'b0;
			end else begin
				unique case (st_r)
					CL_IDLE, CL_IGNORE: oe_r <= 1'b0;
					CL_ADDR: if (scl_rise) begin
						sh_r <= sh_in;
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							rw_r <= sh_in[0];
							ara_r <= ara_match;
							st_r <= (addr_match || ara_match) ? CL_ACK : CL_IGNORE;
							first_r <= 1'b1;
						end
					end
					CL_RX: if (scl_rise) begin
						sh_r <= sh_in;
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							st_r <= CL_ACK;
							if (first_r) begin
								reg_addr <= sh_in;
								first_r <= 1'b0;
							end else begin
								reg_wdata <= sh_in;
								reg_we <= 1'b1;
								adv_r <= 1'b1;
							end
						end
					end
					CL_ACK: if (scl_fall) begin
						if (!oe_r) begin
							oe_r <= 1'b1;
						end else begin
							bit_r <= 3'h0;
							adv_r <= 1'b0;
							if (rw_r) begin
								st_r <= CL_TX;
								sh_r <= tx_byte;
								oe_r <= ~tx_byte[7];
								lost_r <= 1'b0;
								reg_re <= ~ara_r;
							end else begin
								oe_r <= 1'b0;
								// Only a stored byte moves the pointer, never the pointer byte
								if (adv_r) begin
									reg_addr <= reg_addr + 8'h01;
								end
								st_r <= CL_RX;
							end
						end
					end
					CL_TX: begin
						if (scl_rise && !oe_r && !sda) begin
							lost_r <= 1'b1;
						end
						if (scl_fall) begin
							bit_r <= bit_r + 3'h1;
							sh_r <= {sh_r[6:0], 1'b0};
							if (bit_r == 3'h7) begin
								oe_r <= 1'b0;
								st_r <= CL_TACK;
							end else begin
								oe_r <= ~sh_r[6];
							end
						end
					end
					CL_TACK: if (scl_rise) begin
						if (ara_r && !lost_r) begin
							alert_mask <= 1'b1;
						end
						if (sda || ara_r) begin
							st_r <= CL_IGNORE;
						end else begin
							reg_addr <= reg_addr + 8'h01;
						end
					end else if (scl_fall) begin
						// Host acked: next register goes out on this low phase
						st_r <= CL_TX;
						bit_r <= 3'h0;
						sh_r <= tx_byte;
						oe_r <= ~tx_byte[7];
						lost_r <= 1'b0;
						reg_re <= 1'b1;
					end
					default: st_r <= CL_IDLE;
				endcase
			end
		end
	end
endmodule : smb_client

// *** smb_host.sv ***
// Host end: drives the bus clock and runs one transaction per command
`timescale 1ns/10ps
module smb_host #(
	parameter int unsigned DIV = smb_pkg::HOST_DIV
) (
	input wire logic clk_sys,
	input wire logic rstn,
	smb_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_op,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_reg,
	input wire logic [7:0] cmd_data,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	output logic rsp_nack,
	output logic alert_seen
);
	import smb_pkg::*;
	h_state_t st_r;
	logic [15:0] div_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [2:0] idx_r;
	logic [2:0] op_r;
	logic [8:0] sh_r;
	logic [7:0] reg_r;
	logic [7:0] dat_r;
	logic [6:0] adr_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic [1:0] sda_s_r;
	logic [1:0] al_s_r;
	wire tick = div_r == 16'h0000;
	wire rd_op = op_r == OP_READ || op_r == OP_RECV || op_r == OP_ARA;
	wire [2:0] last_idx = op_r == OP_SEND ? 3'h1 : (op_r == OP_WRITE ? 3'h2 : (op_r == OP_READ ? 3'h3 : 3'h1));
	wire rd_byte = rd_op && idx_r == last_idx;
	wire [7:0] first_addr = {(op_r == OP_ARA ? ARA_ADDR : adr_r), (op_r == OP_RECV || op_r == OP_ARA)};
	wire [7:0] next_byte = idx_r == 3'h0 ? reg_r : (op_r == OP_READ ? {adr_r, 1'b1} : dat_r);
	assign cmd_ready = st_r == H_IDLE;
	assign bus.clk_host_oe = scl_oe_r;
	assign bus.dat_host_oe = sda_oe_r;
	assign alert_seen = ~al_s_r[1];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sda_s_r <= 2'h3;
			al_s_r <= 2'h3;
		end else begin
			sda_s_r <= {sda_s_r[0], bus.sda};
			al_s_r <= {al_s_r[0], bus.alert_n};
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= tick || st_r == H_IDLE ? 16'(DIV - 1) : div_r - 16'h0001;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= H_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			idx_r <= 3'h0;
			op_r <= OP_SEND;
			sh_r <= 9'h000;
			reg_r <= 8'h00;
			dat_r <= 8'h00;
			adr_r <= 7'h00;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rsp_data <= 8'h00;
			rsp_valid <= 1'b0;
			rsp_nack <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (st_r)
				H_IDLE: if (cmd_valid) begin
					op_r <= cmd_op;
					adr_r <= cmd_addr;
					reg_r <= cmd_reg;
					dat_r <= cmd_data;
					rsp_nack <= 1'b0;
					ph_r <= 2'h0;
					st_r <= H_START;
				end
				H_START, H_RSTART: if (tick) begin
					ph_r <= ph_r + 2'h1;
					unique case (ph_r)
						2'h0: begin
							sda_oe_r <= 1'b0;
						end
						2'h1: scl_oe_r <= 1'b0;
						2'h2: sda_oe_r <= 1'b1;
						default: begin
							scl_oe_r <= 1'b1;
							sh_r <= {first_addr, 1'b1};
							idx_r <= st_r == H_START ? 3'h0 : 3'h2;
							if (st_r == H_RSTART) begin
								sh_r <= {adr_r, 1'b1, 1'b1};
							end
							bit_r <= 4'h0;
							st_r <= H_BIT;
						end
					endcase
				end
				H_BIT: if (tick) begin
					ph_r <= ph_r + 2'h1;
					unique case (ph_r)
						2'h0: sda_oe_r <= (rd_byte && idx_r != 3'h0) || (rd_op && op_r != OP_READ && bit_r > 4'h7)
							? (bit_r == 4'h8 && !sh_r[8]) : ~sh_r[8];
						2'h1: scl_oe_r <= 1'b0;
						2'h2: sh_r <= {sh_r[7:0], sda_s_r[1]};
						default: begin
							scl_oe_r <= 1'b1;
							bit_r <= bit_r + 4'h1;
							if (bit_r == 4'h8) begin
								st_r <= H_ACK;
							end
						end
					endcase
				end
				H_ACK: begin
					sda_oe_r <= 1'b0;
					if (sh_r[0] && !(rd_op && idx_r == last_idx)) begin
						rsp_nack <= 1'b1;
						st_r <= H_STOP;
					end else if (rd_op && idx_r == last_idx) begin
						rsp_data <= sh_r[8:1];
						rsp_valid <= 1'b1;
						st_r <= H_STOP;
					end else if (idx_r == 3'h1 && op_r == OP_READ) begin
						idx_r <= 3'h2;
						ph_r <= 2'h0;
						st_r <= H_RSTART;
					end else if (idx_r + 3'h1 > last_idx) begin
						st_r <= H_STOP;
					end else begin
						// Read bytes shift in ones, host nacks with released line
						sh_r <= (rd_op && idx_r + 3'h1 == last_idx) ? 9'h1FF : {next_byte, 1'b1};
						idx_r <= idx_r + 3'h1;
						bit_r <= 4'h0;
						ph_r <= 2'h0;
						st_r <= H_BIT;
					end
				end
				H_STOP: if (tick) begin
					ph_r <= ph_r + 2'h1;
					unique case (ph_r)
						2'h0: sda_oe_r <= 1'b1;
						2'h1: scl_oe_r <= 1'b0;
						2'h2: sda_oe_r <= 1'b0;
						default: st_r <= H_IDLE;
					endcase
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end
endmodule : smb_host

// *** smb_if.sv ***
// Two-wire bus carrier with open-drain resolution
`timescale 1ns/10ps
interface smb_if;
	logic clk_host_oe;
	logic dat_host_oe;
	logic dat_dev_oe;
	logic alert_n;
	wire scl = ~clk_host_oe;
	wire sda = ~(dat_host_oe | dat_dev_oe);
	modport client (input scl, input sda, output dat_dev_oe, output alert_n);
	modport host (input scl, input sda, output clk_host_oe, output dat_host_oe, input alert_n);
endinterface : smb_if

// *** smb_pkg.sv ***
// Shared constants for the two-wire register port
package smb_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned TIMEOUT_US = 30000;
	localparam int unsigned IDLE_US = 150;
	localparam int unsigned TIMEOUT_CYC = (TIMEOUT_US / 1000) * (CLK_HZ / 1000);
	localparam int unsigned IDLE_CYC = IDLE_US * (CLK_HZ / 1000000) + 1;
	localparam int unsigned HOST_DIV = 40;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	localparam logic [6:0] OPEN_ADDR = 7'h18;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned BYTE_W = 8;
	localparam logic [3:0] STRAP_OPEN = 4'hF;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		CL_IDLE = 3'b000,
		CL_ADDR = 3'b001,
		CL_ACK = 3'b011,
		CL_RX = 3'b010,
		CL_TX = 3'b110,
		CL_TACK = 3'b111,
		CL_IGNORE = 3'b101
	} cl_state_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_START = 3'b001,
		H_BIT = 3'b011,
		H_ACK = 3'b010,
		H_STOP = 3'b110,
		H_RSTART = 3'b111
	} h_state_t;
	localparam logic [2:0] OP_SEND = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_RECV = 3'h3;
	localparam logic [2:0] OP_ARA = 3'h4;
	// Strap code to client address
	function automatic logic [6:0] strap_addr(input logic [3:0] s);
		logic [6:0] a;
		a = OPEN_ADDR;
		if (s < 4'h4) begin
			a = {5'h13, s[1:0]};
		end else if (s < 4'h8) begin
			a = {5'h12, s[1:0]};
		end else if (s < 4'hF) begin
			a = {4'h5, s[2:0]};
		end
		return a;
	endfunction : strap_addr
endpackage : smb_pkg

// *** smb_port_chk.sv ***
// Bus-level checker for the two-wire register port
`timescale 1ns/10ps
module smb_port_chk (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_host_oe,
	input wire logic dat_host_oe,
	input wire logic dat_dev_oe,
	input wire logic alert_n,
	input wire logic scl,
	input wire logic sda
);
	logic in_frame_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Frame tracker, from start to stop
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			in_frame_r <= 1'b0;
		end else if (scl && $fell(sda)) begin
			in_frame_r <= 1'b1;
		end else if (scl && $rose(sda)) begin
			in_frame_r <= 1'b0;
		end
	end
	a_dev_moves_low: assert property ($changed(dat_dev_oe) |-> !scl)
		else $error("client data moved while clock high");
	a_start_by_host: assert property (scl && $fell(sda) |-> dat_host_oe)
		else $error("start not made by host");
	a_stop_release: assert property (scl && $rose(sda) |=> !dat_dev_oe [*8])
		else $error("client drives data after stop");
	a_dev_quiet_idle: assert property (!in_frame_r |-> !dat_dev_oe)
		else $error("client drives data outside a frame");
	a_no_clk_hold: assert property (!clk_host_oe |-> scl)
		else $error("clock low without host");
	a_clk_low_bound: assert property ($rose(clk_host_oe) |-> ##[1:1000] !clk_host_oe)
		else $error("clock low too long");
	a_clk_high_bound: assert property (in_frame_r && $rose(scl) |-> ##[1:1000] (!scl || !in_frame_r))
		else $error("clock high too long in frame");
	a_clk_only_frame: assert property (!in_frame_r && !(scl && $fell(sda)) |-> scl)
		else $error("clock low outside a frame");
	a_alert_release: assert property (in_frame_r && $rose(alert_n) |-> scl)
		else $error("alert released outside a clock high phase");
endmodule : smb_port_chk

// *** smbus_client_register_port_tb.sv ***
// Bench: host and client ends joined on one bus
`timescale 1ns/10ps
module smbus_client_register_port_tb;
	import smb_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic [2:0] cmd_op = 3'h0;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic alert_req = 1'b0;
	logic alert_mask_clr = 1'b0;
	logic cmd_ready, rsp_valid, rsp_nack, alert_seen, alert_mask, reg_we;
	logic [7:0] rsp_data, reg_addr, reg_wdata;
	logic [6:0] own_addr;
	byte_t regs [256];
	wire [7:0] reg_rdata = regs[reg_addr];
	logic reg_re;
	logic rsp_seen = 1'b0;
	int re_count = 0;
	int bad_count = 0;
	int check_count = 0;
	smb_if bus_if ();
	// Short time-outs keep the run brief
	smb_client #(.TIMEOUT_CYCLES(2000), .IDLE_CYCLES(500)) u_smb_client (.clk_sys(clk_sys), .rstn(rstn),
		.bus(bus_if.client), .addr_strap(4'h0), .timeout_en(1'b1), .idle_en(1'b1), .alert_req(alert_req),
		.alert_mask_clr(alert_mask_clr), .alert_mask(alert_mask), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .own_addr(own_addr));
	smb_host u_smb_host (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .alert_seen(alert_seen));
	smb_port_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .clk_host_oe(bus_if.clk_host_oe),
		.dat_host_oe(bus_if.dat_host_oe), .dat_dev_oe(bus_if.dat_dev_oe), .alert_n(bus_if.alert_n),
		.scl(bus_if.scl), .sda(bus_if.sda));
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (reg_we) begin
			regs[reg_addr] <= reg_wdata;
		end
		if (reg_re === 1'b1) begin
			re_count <= re_count + 1;
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic close_out;
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	task automatic run(input logic [2:0] op, input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
		int i;
		@(negedge clk_sys);
		cmd_op = op;
		cmd_addr = a;
		cmd_reg = r;
		cmd_data = d;
		cmd_valid = 1'b1;
		rsp_seen = 1'b0;
		for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
		if (i == 50) begin
			chk("command taken", 8'h01, 8'h00);
			close_out();
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// Writes and refused frames give no read pulse: wait for the host to go idle
		for (i = 0; i < 20000 && cmd_ready !== 1'b1; i++) begin
			@(negedge clk_sys);
			if (rsp_valid === 1'b1) begin
				rsp_seen = 1'b1;
			end
		end
		if (i == 20000) begin
			chk("response", 8'h01, 8'h00);
			close_out();
		end
	endtask : run
	task automatic s_write_read;
		run(OP_WRITE, 7'h4C, 8'h10, 8'h1E);
		chk("write nack", 8'h00, {7'h00, rsp_nack});
		chk("stored byte", 8'h1E, regs[8'h10]);
		chk("pointer", 8'h11, reg_addr);
		chk("write response", 8'h00, {7'h00, rsp_seen});
		run(OP_READ, 7'h4C, 8'h10, 8'h00);
		chk("read byte", 8'h1E, rsp_data);
		chk("read response", 8'h01, {7'h00, rsp_seen});
		chk("read nack", 8'h00, {7'h00, rsp_nack});
	endtask : s_write_read
	task automatic s_send_recv;
		int n;
		run(OP_SEND, 7'h4C, 8'h20, 8'h00);
		chk("send pointer", 8'h20, reg_addr);
		chk("no data", 8'hE3, regs[8'h20]);
		n = re_count;
		run(OP_RECV, 7'h4C, 8'h00, 8'h00);
		chk("receive byte", 8'hE3, rsp_data);
		chk("read strobe", 8'h01, 8'(re_count - n));
		run(OP_RECV, 7'h4C, 8'h00, 8'h00);
		chk("receive again", 8'hE3, rsp_data);
		chk("pointer kept", 8'h20, reg_addr);
	endtask : s_send_recv
	task automatic s_foreign;
		// Differs from own address in the last bit only
		run(OP_WRITE, 7'h4D, 8'h30, 8'h00);
		chk("foreign nack", 8'h01, {7'h00, rsp_nack});
		chk("foreign store", 8'hF3, regs[8'h30]);
		run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
		chk("quiet alert nack", 8'h01, {7'h00, rsp_nack});
	endtask : s_foreign
	task automatic s_alert;
		int i;
		int n;
		alert_req = 1'b1;
		for (i = 0; i < 100 && alert_seen !== 1'b1; i++) @(negedge clk_sys);
		chk("alert seen", 8'h01, {7'h00, alert_seen});
		n = re_count;
		run(OP_ARA, ARA_ADDR, 8'h00, 8'h00);
		chk("own address", 8'h4C, {1'b0, own_addr});
		chk("alert answer", 8'h4C, {1'b0, rsp_data[7:1]});
		chk("alert ack", 8'h00, {7'h00, rsp_nack});
		chk("alert reads no register", 8'h00, 8'(re_count - n));
		chk("mask set", 8'h01, {7'h00, alert_mask});
		chk("alert released", 8'h00, {7'h00, alert_seen});
		alert_req = 1'b0;
		alert_mask_clr = 1'b1;
		@(negedge clk_sys);
		alert_mask_clr = 1'b0;
		@(negedge clk_sys);
		chk("mask cleared", 8'h00, {7'h00, alert_mask});
	endtask : s_alert
	initial begin
		for (int k = 0; k < 256; k++) regs[k] = 8'(k) ^ 8'hC3;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (2) @(negedge clk_sys);
		s_write_read();
		s_send_recv();
		s_foreign();
		s_alert();
		close_out();
	end
endmodule : smbus_client_register_port_tb
